// ---- tb/nvsc_host_checker.sv ----
`timescale 1ns/1ps
module nvsc_host_checker (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // Observed ports
  input wire logic        req_ready_o,
  input wire logic        rsp_valid_o,
  input wire logic        ce_n_o,
  input wire logic        oe_n_o,
  input wire logic        we_n_o,
  input wire logic [14:0] address_bus_o,
  input wire logic [7:0]  data_pins_o,
  input wire logic        data_pins_oe_o,
  input wire logic        hw_store_busy_n_i,
  input wire logic        hw_store_busy_n_o,
  input wire logic        hw_store_busy_n_oe_o
);
  // ------------------------------
  // Pin protocol
  // ------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_read_go;
    $fell(oe_n_o) && !ce_n_o;
  endsequence
  sequence s_write_on;
    !ce_n_o && !we_n_o;
  endsequence
  a_read_ctrl: assert property (!oe_n_o |-> !ce_n_o && we_n_o)
    else $error("read strobes wrong");
  a_read_end: assert property (s_read_go |-> ##[1:40] $rose(oe_n_o))
    else $error("read never ends");
  a_write_drive: assert property (
    s_write_on |-> data_pins_oe_o && oe_n_o)
    else $error("write without data drive");
  a_write_hold: assert property (
    s_write_on ##1 s_write_on |-> $stable(address_bus_o)
      && $stable(data_pins_o))
    else $error("write address or data moved");
  a_no_write_busy: assert property (
    $fell(we_n_o) |-> hw_store_busy_n_i)
    else $error("write started while busy");
  a_idle_in_store: assert property (
    !hw_store_busy_n_i && !hw_store_busy_n_oe_o |-> ce_n_o)
    else $error("access during store");
  a_answer_bound: assert property (
    req_ready_o |-> ##[1:200] rsp_valid_o)
    else $error("no answer in time");
  a_busy_pull: assert property (
    hw_store_busy_n_oe_o |-> !hw_store_busy_n_o && ce_n_o && we_n_o)
    else $error("busy line driven high");
endmodule // nvsc_host_checker

bind nvsc_host nvsc_host_checker u_nvsc_host_checker (.clk_i, .rst_n_i,
  .req_ready_o, .rsp_valid_o, .ce_n_o, .oe_n_o, .we_n_o, .address_bus_o,
  .data_pins_o, .data_pins_oe_o, .hw_store_busy_n_i, .hw_store_busy_n_o,
  .hw_store_busy_n_oe_o);

// ---- tb/nvsc_host_test.sv ----
`timescale 1ns/1ps
module nvsc_host_test;
  logic                clk_i, rst_n_i, req_valid;
  nvsc_pkg::nvsc_req_t req;
  logic                rdy, rsp, ce_n, oe_n, we_n, d_oe, h_o, h_oe, m_h;
  logic                busy, low_sup;
  logic [7:0]          rsp_data, d_o, m_data, q, sc;
  logic [14:0]         addr;
  logic [14:0]         ad [16];
  logic [7:0]          dv [16];
  int                  mismatches, total_checks;
  wire  [7:0]          data_w = d_oe ? d_o : m_data;
  wire                 busy_w = !(h_oe || m_h);
  nvsc_host #(.STORE_CYC(20), .RECALL_CYC(5), .DELAY_CYC(5), .ACC_CYC(6))
  u_nvsc_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid),
    .req_i(req), .req_ready_o(rdy), .rsp_valid_o(rsp), .rsp_data_o(rsp_data),
    .nv_busy_o(busy), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n),
    .address_bus_o(addr), .data_pins_i(data_w), .data_pins_o(d_o),
    .data_pins_oe_o(d_oe), .hw_store_busy_n_i(busy_w),
    .hw_store_busy_n_o(h_o), .hw_store_busy_n_oe_o(h_oe));
  nvsc_nvram_model u_nvsc_nvram_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr),
    .data_i(data_w), .data_o(m_data), .busy_n_i(busy_w),
    .busy_oe_o(m_h), .supply_low_i(low_sup));
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic wrap_up();
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic op(input nvsc_pkg::nvsc_op_t o, input logic [14:0] a,
                    input logic [7:0] d);
    int n;
    n = 0;
    req <= '{o, a, d};
    req_valid <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (rdy !== 1'b1 && n < 3000);
    req_valid <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp !== 1'b1 && n < 3000);
    q = rsp_data;
    if (n >= 3000) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic read_all();
    for (int i = 0; i < 16; i++) begin
      op(nvsc_pkg::NVSC_OP_READ, ad[i], 8'h00);
      check(32'(q), 32'(dv[i]));
    end
  endtask
  task automatic stores(input nvsc_pkg::nvsc_op_t o, input logic [7:0] e);
    op(o, 15'h0000, 8'h00);
    check(32'(u_nvsc_nvram_model.store_cnt), 32'(e));
  endtask
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    {rst_n_i, req_valid, low_sup, req, q, mismatches, total_checks} = '0;
    void'($urandom(84));
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    check(32'(u_nvsc_nvram_model.auto_en), 32'h1);
    for (int i = 0; i < 16; i++) begin
      ad[i] = {i[3:0], (i == 15) ? 11'h7FF : (i == 0) ? 11'h000
                                 : 11'($urandom)};
      dv[i] = 8'($urandom);
      op(nvsc_pkg::NVSC_OP_WRITE, ad[i], dv[i]);
    end
    read_all();
    sc = u_nvsc_nvram_model.store_cnt;
    stores(nvsc_pkg::NVSC_OP_HW_STORE, sc + 8'h01);
    stores(nvsc_pkg::NVSC_OP_HW_STORE, sc + 8'h01);
    stores(nvsc_pkg::NVSC_OP_SW_STORE, sc + 8'h02);
    for (int i = 0; i < 16; i++)
      op(nvsc_pkg::NVSC_OP_WRITE, ad[i], ~dv[i]);
    op(nvsc_pkg::NVSC_OP_SW_RECALL, 15'h0000, 8'h00);
    read_all();
    op(nvsc_pkg::NVSC_OP_AS_OFF, 15'h0000, 8'h00);
    check(32'(u_nvsc_nvram_model.auto_en), 32'h0);
    op(nvsc_pkg::NVSC_OP_AS_ON, 15'h0000, 8'h00);
    check(32'(u_nvsc_nvram_model.auto_en), 32'h1);
    // Power-fail store, then a write refused under low supply
    op(nvsc_pkg::NVSC_OP_WRITE, ad[1], ~dv[1]);
    low_sup <= 1'b1;
    repeat (4) @(posedge clk_i);
    check(32'(busy), 32'h1);
    repeat (20) @(posedge clk_i);
    check(32'(busy), 32'h0);
    check(32'(u_nvsc_nvram_model.store_cnt), 32'(sc + 8'h03));
    op(nvsc_pkg::NVSC_OP_WRITE, ad[1], dv[1]);
    low_sup <= 1'b0;
    op(nvsc_pkg::NVSC_OP_READ, ad[1], 8'h00);
    check(32'(q), 32'(8'(~dv[1])));
    wrap_up();
  end
endmodule // nvsc_host_test

// ---- tb/nvsc_nvram_model.sv ----
`timescale 1ns/1ps
module nvsc_nvram_model #(
  parameter int unsigned ST_CYC = 12,
  parameter int unsigned RC_CYC = 3,
  parameter int unsigned DL_CYC = 3
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Memory pins
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [14:0] addr_i,
  input  wire logic [7:0]  data_i,
  output logic      [7:0]  data_o,
  input  wire logic        busy_n_i,
  output logic             busy_oe_o,
  // Supply below the low-voltage threshold
  input  wire logic        supply_low_i
);
  localparam logic [13:0] SEQ [5] = '{nvsc_pkg::SEQ_A0, nvsc_pkg::SEQ_A1,
    nvsc_pkg::SEQ_A2, nvsc_pkg::SEQ_A3, nvsc_pkg::SEQ_A4};
  logic [7:0]  mem [32768];
  logic [7:0]  nv  [32768];
  logic [7:0]  last_q, pd, store_cnt;
  logic [14:0] pa;
  logic [15:0] cnt, dlc;
  logic [2:0]  step;
  logic        prev_rd, prev_wr, prev_busy, prev_low, wr_lock;
  logic        dirty, auto_en;
  wire idle = (cnt == 16'h0000);
  // Reads need write enable high, drivers off in writes
  // Accesses ignored while store or recall runs
  wire rd = !ce_n_i && !oe_n_i && we_n_i && busy_n_i && idle;
  wire wr = !ce_n_i && !we_n_i && busy_n_i && idle
    && !supply_low_i && !wr_lock;
  wire rd_end = prev_rd && (!rd || addr_i != pa);
  wire hit = step < 3'h5 && pa[13:0] == SEQ[step];
  wire cmd = rd_end && step == 3'h5;
  wire sw_st = cmd && pa[13:0] == nvsc_pkg::CMD_STORE
    && !supply_low_i;
  wire sw_rc = cmd && pa[13:0] == nvsc_pkg::CMD_RECALL;
  wire hw_st = dlc == 16'h0001 && dirty
    && !supply_low_i;
  wire pf_st = supply_low_i && !prev_low && auto_en && dirty;
  wire fall = prev_busy && !busy_n_i && !busy_oe_o;
  // Released bus toggles so a stale value never looks valid
  assign data_o = rd ? mem[addr_i] : ~last_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {prev_rd, prev_wr, dirty, step, cnt, dlc, store_cnt} <= '0;
      {last_q, pd, pa, busy_oe_o} <= '0;
      prev_busy <= 1'b1;
      prev_low <= 1'b0;
      wr_lock <= 1'b1;
      auto_en <= 1'b1;
    end else begin
      prev_rd <= rd;
      prev_wr <= wr;
      prev_busy <= busy_n_i;
      prev_low <= supply_low_i;
      last_q <= data_o;
      pa <= addr_i;
      pd <= data_i;
      if (ce_n_i || we_n_i)
        wr_lock <= 1'b0;
      cnt <= cnt - 16'(!idle);
      dlc <= fall ? 16'(DL_CYC) : dlc - 16'(dlc != 16'h0000);
      if (cnt == 16'h0001) begin
        busy_oe_o <= 1'b0;
        if (!ce_n_i && !we_n_i)
          wr_lock <= 1'b1;
      end
      if (prev_wr && !wr) begin
        mem[pa] <= pd;
        dirty <= 1'b1;
        step <= '0;
      end else if (rd_end)
        step <= hit ? step + 3'h1 : '0;
      if (cmd && pa[13:0] == nvsc_pkg::CMD_AS_OFF)
        auto_en <= 1'b0;
      if (cmd && pa[13:0] == nvsc_pkg::CMD_AS_ON)
        auto_en <= 1'b1;
      if (sw_st || hw_st || pf_st) begin
        nv <= mem;
        cnt <= 16'(ST_CYC);
        busy_oe_o <= 1'b1;
        dirty <= 1'b0;
        store_cnt <= store_cnt + 8'h01;
      end
      if (sw_rc) begin
        mem <= nv;
        cnt <= 16'(RC_CYC);
        dirty <= 1'b0;
      end
    end
  end
endmodule // nvsc_nvram_model

// ---- verilog/nvsc_host.sv ----
`timescale 1ns/1ps
//
// Contract
// - Address and data held stable through write end.
// - Software store: six reads ending 0x0FC0.
// - Software recall: same five reads then 0x0C63.
// - Sequence steps are reads only, never writes.
// - Sixth read 0x03F8 disables, 0x07F0 enables automatic store.
module nvsc_host #(
  parameter int unsigned STORE_CYC  = nvsc_pkg::STORE_CYC,
  parameter int unsigned RECALL_CYC = nvsc_pkg::RECALL_CYC,
  parameter int unsigned DELAY_CYC  = nvsc_pkg::DELAY_CYC,
  parameter int unsigned ACC_CYC    = nvsc_pkg::ACC_CYC
) (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // User request
  input  wire logic                        req_valid_i,
  input  wire nvsc_pkg::nvsc_req_t         req_i,
  output logic                             req_ready_o,
  output logic                             rsp_valid_o,
  output logic [nvsc_pkg::DATA_W-1:0]      rsp_data_o,
  output logic                             nv_busy_o,
  // Memory pins
  output logic                             ce_n_o,
  output logic                             oe_n_o,
  output logic                             we_n_o,
  output logic [nvsc_pkg::ADDR_W-1:0]      address_bus_o,
  input  wire logic [nvsc_pkg::DATA_W-1:0] data_pins_i,
  output logic [nvsc_pkg::DATA_W-1:0]      data_pins_o,
  output logic                             data_pins_oe_o,
  input  wire logic                        hw_store_busy_n_i,
  output logic                             hw_store_busy_n_o,
  output logic                             hw_store_busy_n_oe_o
);

  localparam int unsigned TW = 24;

  // Timer and access counter must hold every load value
  if (DELAY_CYC + STORE_CYC >= (1 << TW) || RECALL_CYC >= (1 << TW) ||
      ACC_CYC < 2 || ACC_CYC > 255) begin : g_bad_timing
    $error("nvsc_host: timing parameter out of range");
  end

  typedef enum {
    S_IDLE, S_SETUP, S_ACT, S_GAP, S_SEQ, S_WAIT, S_PULL
  } nvsc_state_t;

  nvsc_state_t          st_reg;
  nvsc_pkg::nvsc_req_t  cur_reg;
  logic [2:0]           step_reg;
  logic [7:0]           acc_reg;
  logic                 t_start;
  logic [TW-1:0]        t_load;
  logic                 t_busy;
  logic                 t_done;

  // ----------------------------------------------------------------
  // Sequence address per step
  // ----------------------------------------------------------------
  function automatic logic [nvsc_pkg::CMD_W-1:0] seq_addr(
    input logic [2:0] step, input nvsc_pkg::nvsc_op_t op);
    case (step)
      3'h0: seq_addr = nvsc_pkg::SEQ_A0;
      3'h1: seq_addr = nvsc_pkg::SEQ_A1;
      3'h2: seq_addr = nvsc_pkg::SEQ_A2;
      3'h3: seq_addr = nvsc_pkg::SEQ_A3;
      3'h4: seq_addr = nvsc_pkg::SEQ_A4;
      default: begin
        case (op)
          nvsc_pkg::NVSC_OP_SW_RECALL: seq_addr = nvsc_pkg::CMD_RECALL;
          nvsc_pkg::NVSC_OP_AS_OFF:    seq_addr = nvsc_pkg::CMD_AS_OFF;
          nvsc_pkg::NVSC_OP_AS_ON:     seq_addr = nvsc_pkg::CMD_AS_ON;
          default:                     seq_addr = nvsc_pkg::CMD_STORE;
        endcase
      end
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire is_rd   = (cur_reg.op == nvsc_pkg::NVSC_OP_READ);
  wire is_wr   = (cur_reg.op == nvsc_pkg::NVSC_OP_WRITE);
  wire is_hw   = (cur_reg.op == nvsc_pkg::NVSC_OP_HW_STORE);
  wire is_seq  = !is_rd && !is_wr && !is_hw;
  wire last_st = (step_reg == 3'h5);
  wire bsy_low = !hw_store_busy_n_i;
  wire acc_end = (acc_reg == 8'h01);
  // Sequence reads use 14 bits; top bit kept low
  wire [nvsc_pkg::ADDR_W-1:0] seq_a =
    {1'b0, seq_addr(step_reg, cur_reg.op)};
  wire [TW-1:0] wait_load =
    (cur_reg.op == nvsc_pkg::NVSC_OP_SW_RECALL) ? TW'(RECALL_CYC) :
    (cur_reg.op == nvsc_pkg::NVSC_OP_SW_STORE)  ? TW'(STORE_CYC)  :
    (is_hw ? TW'(DELAY_CYC) : TW'(1));

  // Idle only when device not busy and no timed wait
  wire can_take = (st_reg == S_IDLE) && !bsy_low && !t_busy;

  assign t_start = (st_reg == S_SEQ) && acc_end && last_st;
  assign t_load  = wait_load;

  nvsc_timer #(.W(TW)) u_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (t_start || (st_reg == S_PULL && acc_end)),
    .load_i  (is_hw ? TW'(DELAY_CYC) + TW'(STORE_CYC) : t_load),
    .busy_o  (t_busy),
    .done_o  (t_done)
  );

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg               <= S_IDLE;
      cur_reg              <= '0;
      step_reg             <= 3'h0;
      acc_reg              <= 8'h00;
      req_ready_o          <= 1'b0;
      rsp_valid_o          <= 1'b0;
      rsp_data_o           <= '0;
      nv_busy_o            <= 1'b0;
      ce_n_o               <= 1'b1;
      oe_n_o               <= 1'b1;
      we_n_o               <= 1'b1;
      address_bus_o        <= '0;
      data_pins_o          <= '0;
      data_pins_oe_o       <= 1'b0;
      hw_store_busy_n_o    <= 1'b0;
      hw_store_busy_n_oe_o <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      req_ready_o <= 1'b0;
      nv_busy_o   <= t_busy || bsy_low || (st_reg == S_WAIT);
      case (st_reg)
        S_IDLE: begin
          if (can_take && req_valid_i && !req_ready_o) begin
            req_ready_o <= 1'b1;
            cur_reg     <= req_i;
            step_reg    <= 3'h0;
            acc_reg     <= 8'(ACC_CYC);
            st_reg      <= S_SETUP;
          end
        end
        S_SETUP: begin
          // Address before strobes, held through access
          address_bus_o <= is_seq ? seq_a : cur_reg.addr;
          data_pins_o   <= cur_reg.wdata;
          if (is_hw) begin
            hw_store_busy_n_oe_o <= 1'b1;
            st_reg               <= S_PULL;
          end else begin
            st_reg <= is_seq ? S_SEQ : S_ACT;
          end
        end
        S_ACT: begin
          // Fresh falling edge on select each access
          ce_n_o         <= 1'b0;
          oe_n_o         <= !is_rd;
          we_n_o         <= !is_wr;
          data_pins_oe_o <= is_wr;
          acc_reg        <= acc_reg - 8'h01;
          if (acc_end) begin
            ce_n_o         <= 1'b1;
            oe_n_o         <= 1'b1;
            we_n_o         <= 1'b1;
            rsp_valid_o    <= 1'b1;
            rsp_data_o     <= data_pins_i;
            st_reg         <= S_GAP;
          end
        end
        S_GAP: begin
          data_pins_oe_o <= 1'b0;
          st_reg         <= S_IDLE;
        end
        S_SEQ: begin
          // Select-controlled reads only, write enable high
          ce_n_o  <= 1'b0;
          oe_n_o  <= 1'b0;
          we_n_o  <= 1'b1;
          acc_reg <= acc_reg - 8'h01;
          if (acc_end) begin
            ce_n_o   <= 1'b1;
            oe_n_o   <= 1'b1;
            acc_reg  <= 8'(ACC_CYC);
            step_reg <= step_reg + 3'h1;
            address_bus_o <=
              {1'b0, seq_addr(step_reg + 3'h1, cur_reg.op)};
            if (last_st) begin
              // Store and recall lock out access
              st_reg <= S_WAIT;
            end
          end
        end
        S_PULL: begin
          acc_reg <= acc_reg - 8'h01;
          if (acc_end) begin
            hw_store_busy_n_oe_o <= 1'b0;
            st_reg               <= S_WAIT;
          end
        end
        S_WAIT: begin
          // Hold off until timer done, or until timer idle and busy line clear
          if (t_done || (!t_busy && !bsy_low)) begin
            rsp_valid_o <= 1'b1;
            st_reg      <= S_IDLE;
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

endmodule // nvsc_host

// ---- verilog/nvsc_pkg.sv ----
package nvsc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CMD_W  = 14;

  // ----------------------------------------------------------------
  // Timing (clock 125 MHz)
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned CYC_NS           = 8;
  localparam int unsigned HW_STORE_DELAY_US = 70;
  localparam int unsigned STORE_TIME_US10  = 125;
  localparam int unsigned RECALL_TIME_US   = 50;
  localparam int unsigned STORE_CYC  = STORE_TIME_US10 * 100 * CLK_MHZ;
  localparam int unsigned RECALL_CYC = RECALL_TIME_US * CLK_MHZ;
  localparam int unsigned DELAY_CYC  = HW_STORE_DELAY_US * CLK_MHZ;
  localparam int unsigned ACC_CYC    = 6;
  localparam int unsigned BUSY_PULSE_CYC = 2;

  // ----------------------------------------------------------------
  // Command sequence addresses
  // ----------------------------------------------------------------
  localparam logic [CMD_W-1:0] SEQ_A0 = 14'h0E38;
  localparam logic [CMD_W-1:0] SEQ_A1 = 14'h31C7;
  localparam logic [CMD_W-1:0] SEQ_A2 = 14'h03E0;
  localparam logic [CMD_W-1:0] SEQ_A3 = 14'h3C1F;
  localparam logic [CMD_W-1:0] SEQ_A4 = 14'h303F;
  localparam logic [CMD_W-1:0] CMD_STORE   = 14'h0FC0;
  localparam logic [CMD_W-1:0] CMD_RECALL  = 14'h0C63;
  localparam logic [CMD_W-1:0] CMD_AS_OFF  = 14'h03F8;
  localparam logic [CMD_W-1:0] CMD_AS_ON   = 14'h07F0;

  // ----------------------------------------------------------------
  // Host requests
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    NVSC_OP_READ,
    NVSC_OP_WRITE,
    NVSC_OP_SW_STORE,
    NVSC_OP_SW_RECALL,
    NVSC_OP_AS_OFF,
    NVSC_OP_AS_ON,
    NVSC_OP_HW_STORE
  } nvsc_op_t;

  typedef struct packed {
    nvsc_op_t            op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } nvsc_req_t;

  typedef struct packed {
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic [ADDR_W-1:0]   addr;
  } nvsc_bus_t;

endpackage

// ---- verilog/nvsc_timer.sv ----
`timescale 1ns/1ps
// Down counter: loads on start, done pulses when it reaches zero
module nvsc_timer #(
  parameter int unsigned W = 24
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Control
  input  wire logic         start_i,
  input  wire logic [W-1:0] load_i,
  output logic              busy_o,
  output logic              done_o
);

  logic [W-1:0] cnt_reg;
  wire          at_one = (cnt_reg == W'(1));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      done_o  <= 1'b0;
    end else begin
      done_o <= busy_o && at_one && !start_i;
      if (start_i) begin
        cnt_reg <= load_i;
      end else if (busy_o) begin
        cnt_reg <= cnt_reg - W'(1);
      end
    end
  end

  assign busy_o = (cnt_reg != '0);

endmodule // nvsc_timer
